// File: verilog/tmx_regs.vh
// Constants for the translation-miss exception unit.
// Assumes a 32-bit address space with 4 KB pages and a 2 GB user range.
`ifndef TMX_REGS_VH
`define TMX_REGS_VH

// Register offsets on the plain register port
`define OFF_STATUS      4'h0
`define OFF_CAUSE       4'h1
`define OFF_RET_PC      4'h2
`define OFF_PTE_PTR     4'h3
`define OFF_BAD_ADDR    4'h4
`define OFF_IRQ_MASK    4'h5
`define OFF_EVT_STATUS  4'h6
`define OFF_EVT_MASK    4'h7
`define OFF_VEC_GENERAL 4'h8
`define OFF_VEC_USER    4'h9

// Page and segment layout
`define PAGE_SHIFT      12
`define VPN_WIDTH       19
`define USER_TOP_BIT    31
`define SEG_CACHED      3'h4
`define SEG_UNCACHED    3'h5

// Status stack fields: {old_ie, old_km, prev_ie, prev_km, cur_ie, cur_km}
`define ST_CUR_KM       0
`define ST_CUR_IE       1
`define ST_WIDTH        6
`define ST_RESET        6'h01

// Cause codes
`define CAUSE_INT       2'h0
`define CAUSE_TLB       2'h1
`define CAUSE_TRAP      2'h2

// Event status bits
`define EV_UMISS        0
`define EV_KMISS        1
`define EV_INT          2
`define EV_NEST         3
`define EV_WIDTH        4

// Reset values
`define VEC_GENERAL_RST 32'h8000_0080
`define VEC_USER_RST    32'h8000_0000
`endif

// File: verilog/seg_decode.v
// Address segment decoder for translation.
// Assumes a 32-bit virtual address presented by the core.
`include "tmx_regs.vh"
module seg_decode (
  // Address
  input  wire [31:0] vaddr,
  // Classification
  output wire        is_user,
  output wire        is_unmapped
);
  assign is_user     = ~vaddr[`USER_TOP_BIT];
  assign is_unmapped = (vaddr[31:29] == `SEG_CACHED) | (vaddr[31:29] == `SEG_UNCACHED);
endmodule

// File: verilog/stat_stack.v
// Three-level mode and interrupt-enable stack.
// Assumes push and pop never arrive together.
`include "tmx_regs.vh"
module stat_stack (
  // Clock and reset
  input  wire                 sys_clk,
  input  wire                 resetn,
  // Control
  input  wire                 push,
  input  wire                 pop,
  input  wire                 wr_en,
  input  wire [`ST_WIDTH-1:0] wr_data,
  // State
  output reg  [`ST_WIDTH-1:0] stack_r
);
  always @(posedge sys_clk) begin
    if (!resetn) begin
      stack_r <= `ST_RESET;
    end else if (push) begin
      stack_r <= {stack_r[3:0], 2'b01}; // [RQ9]
    end else if (pop) begin
      stack_r <= {stack_r[5:4], stack_r[5:2]}; // [RQ9]
    end else if (wr_en) begin
      stack_r <= wr_data;
    end
  end
endmodule

// File: verilog/translation_miss_exceptions.v
// Exception-entry unit: translation misses, interrupts, status stack.
// Assumes the core presents translation requests and lookup results in one cycle.
//
// Summary of operation
// RQ1: No matching entry raises translation-miss exception.
// RQ2: User misses go to dedicated vector; nested ones use the general vector.
// RQ3: Unmapped kernel segments never consult translation.
// RQ4: Page-table pointer shows missing page entry.
// RQ5: Status holds three-deep mode/enable stack.
// RQ6: Nested exception overwrites return address.
// RQ7: Interrupts gated by unprioritised mask.
// RQ8: 4 KB pages over 2 GB user range.
// RQ9: Entry pushes kernel/disabled; return pops.
// RQ10: Interrupt needs unmasked input and enable.
`include "tmx_regs.vh"
module translation_miss_exceptions #(
  parameter IRQ_WIDTH = 6
) (
  // Clock and reset
  input  wire                 sys_clk,
  input  wire                 resetn,
  // Translation request
  input  wire                 xlate_valid,
  input  wire [31:0]          xlate_vaddr,
  input  wire [31:0]          xlate_pc,
  input  wire                 tlb_hit,
  output wire                 tlb_lookup,
  // Other traps and return
  input  wire                 trap_req,
  input  wire [31:0]          trap_pc,
  input  wire                 eret,
  // Interrupt inputs
  input  wire [IRQ_WIDTH-1:0] irq_in,
  input  wire [31:0]          cur_pc,
  // Exception entry to the core
  output reg                  exc_take,
  output reg  [31:0]          exc_vector,
  output wire                 kernel_mode,
  // Register port
  input  wire [3:0]           reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  // Event interrupt
  output wire                 evt_irq
);
  wire                 is_user;
  wire                 is_unmapped;
  wire [`ST_WIDTH-1:0] stack_r;
  reg  [31:0]          ret_pc_r;
  reg  [31:0]          bad_addr_r;
  reg  [31:0]          pte_ptr_r;
  reg  [1:0]           cause_r;
  reg                  in_exc_r;
  reg  [IRQ_WIDTH-1:0] irq_mask_r;
  reg  [`EV_WIDTH-1:0] evt_stat_r;
  reg  [`EV_WIDTH-1:0] evt_mask_r;
  reg  [`EV_WIDTH-1:0] evt_set;
  reg  [31:0]          vec_gen_r;
  reg  [31:0]          vec_user_r;
  reg  [31:0]          reg_rdata_nxt;
  wire                 miss;
  wire                 irq_pend;
  wire                 take;
  wire                 st_wr;

  seg_decode u_seg (
    .vaddr       (xlate_vaddr),
    .is_user     (is_user),
    .is_unmapped (is_unmapped)
  );

  assign tlb_lookup = xlate_valid & ~is_unmapped;     // [RQ3]
  assign miss       = tlb_lookup & ~tlb_hit;          // [RQ1]
  assign irq_pend   = |(irq_in & irq_mask_r);         // [RQ7]
  assign take       = miss | trap_req | (irq_pend & stack_r[`ST_CUR_IE]); // [RQ10]
  assign st_wr      = reg_wr & (reg_addr == `OFF_STATUS);
  assign kernel_mode = stack_r[`ST_CUR_KM];

  stat_stack u_stack (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .push    (take),
    .pop     (eret & ~take),
    .wr_en   (st_wr),
    .wr_data (reg_wdata[`ST_WIDTH-1:0]),
    .stack_r (stack_r)
  ); // [RQ5]

  // Exception entry
  always @(posedge sys_clk) begin
    if (!resetn) begin
      exc_take   <= 1'b0;
      exc_vector <= 32'h0000_0000;
      ret_pc_r   <= 32'h0000_0000;
      bad_addr_r <= 32'h0000_0000;
      pte_ptr_r  <= 32'h0000_0000;
      cause_r    <= `CAUSE_INT;
      in_exc_r   <= 1'b0;
    end else begin
      exc_take <= take;
      if (take) begin
        in_exc_r <= 1'b1;
        if (miss) begin
          ret_pc_r   <= xlate_pc;                     // [RQ6]
          bad_addr_r <= xlate_vaddr;
          pte_ptr_r[31:`VPN_WIDTH+2] <= pte_ptr_r[31:`VPN_WIDTH+2];
          pte_ptr_r[`VPN_WIDTH+1:2]  <= xlate_vaddr[30:`PAGE_SHIFT]; // [RQ4] [RQ8]
          pte_ptr_r[1:0]             <= 2'b00;
          cause_r    <= `CAUSE_TLB;
          exc_vector <= (is_user & ~in_exc_r) ? vec_user_r : vec_gen_r; // [RQ2]
        end else if (trap_req) begin
          ret_pc_r   <= trap_pc;                      // [RQ6]
          cause_r    <= `CAUSE_TRAP;
          exc_vector <= vec_gen_r;
        end else begin
          ret_pc_r   <= cur_pc;                       // [RQ6]
          cause_r    <= `CAUSE_INT;
          exc_vector <= vec_gen_r;
        end
      end else if (eret) begin
        in_exc_r <= 1'b0;
      end
      if (reg_wr & (reg_addr == `OFF_PTE_PTR)) begin
        pte_ptr_r[31:`VPN_WIDTH+2] <= reg_wdata[31:`VPN_WIDTH+2];
      end
      if (reg_wr & (reg_addr == `OFF_RET_PC) & ~take) begin
        ret_pc_r <= reg_wdata;
      end
    end
  end

  // Event flags: set wins over clear
  always @* begin
    evt_set = {`EV_WIDTH{1'b0}};
    evt_set[`EV_UMISS] = miss & is_user;
    evt_set[`EV_KMISS] = miss & ~is_user;
    evt_set[`EV_INT]   = take & ~miss & ~trap_req;
    evt_set[`EV_NEST]  = take & in_exc_r;
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      evt_stat_r <= {`EV_WIDTH{1'b0}};
      evt_mask_r <= {`EV_WIDTH{1'b0}};
      irq_mask_r <= {IRQ_WIDTH{1'b0}};
      vec_gen_r  <= `VEC_GENERAL_RST;
      vec_user_r <= `VEC_USER_RST;
    end else begin
      if (reg_wr & (reg_addr == `OFF_EVT_STATUS)) begin
        evt_stat_r <= (evt_stat_r & ~reg_wdata[`EV_WIDTH-1:0]) | evt_set;
      end else begin
        evt_stat_r <= evt_stat_r | evt_set;
      end
      if (reg_wr & (reg_addr == `OFF_EVT_MASK)) begin
        evt_mask_r <= reg_wdata[`EV_WIDTH-1:0];
      end
      if (reg_wr & (reg_addr == `OFF_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata[IRQ_WIDTH-1:0];         // [RQ7]
      end
      if (reg_wr & (reg_addr == `OFF_VEC_GENERAL)) begin
        vec_gen_r <= reg_wdata;
      end
      if (reg_wr & (reg_addr == `OFF_VEC_USER)) begin
        vec_user_r <= reg_wdata;
      end
    end
  end

  assign evt_irq = |(evt_stat_r & evt_mask_r);

  // Read port
  always @* begin
    reg_rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      `OFF_STATUS:      reg_rdata_nxt[`ST_WIDTH-1:0] = stack_r;
      `OFF_CAUSE:       reg_rdata_nxt[1:0] = cause_r;
      `OFF_RET_PC:      reg_rdata_nxt = ret_pc_r;
      `OFF_PTE_PTR:     reg_rdata_nxt = pte_ptr_r;
      `OFF_BAD_ADDR:    reg_rdata_nxt = bad_addr_r;
      `OFF_IRQ_MASK:    reg_rdata_nxt[IRQ_WIDTH-1:0] = irq_mask_r;
      `OFF_EVT_STATUS:  reg_rdata_nxt[`EV_WIDTH-1:0] = evt_stat_r;
      `OFF_EVT_MASK:    reg_rdata_nxt[`EV_WIDTH-1:0] = evt_mask_r;
      `OFF_VEC_GENERAL: reg_rdata_nxt = vec_gen_r;
      `OFF_VEC_USER:    reg_rdata_nxt = vec_user_r;
      default:          reg_rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// File: sim/translation_miss_exceptions_props.sv
// Checker for the translation-miss exception unit.
// Assumes it is bound onto the top module's ports.
`include "tmx_regs.vh"
module tmx_props #(parameter IRQ_WIDTH = 6) (
  // Clock and reset
  input logic                 sys_clk,
  input logic                 resetn,
  // Translation and causes
  input logic                 xlate_valid,
  input logic [31:0]          xlate_vaddr,
  input logic                 tlb_hit,
  input logic                 tlb_lookup,
  input logic                 trap_req,
  input logic [IRQ_WIDTH-1:0] irq_in,
  // Exception entry
  input logic                 exc_take,
  input logic [31:0]          exc_vector,
  input logic                 kernel_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_unmap; xlate_vaddr[31:30] == 2'b10 |-> !tlb_lookup; endproperty
  a_unmap: assert property (p_unmap) else $error("lookup in unmapped segment");
  property p_look; xlate_valid && xlate_vaddr[31:30] != 2'b10 |-> tlb_lookup; endproperty
  a_look: assert property (p_look) else $error("mapped address not looked up");
  property p_miss; tlb_lookup && !tlb_hit |=> exc_take; endproperty
  a_miss: assert property (p_miss) else $error("miss without exception");
  property p_uvec; tlb_lookup && !tlb_hit && !xlate_vaddr[31] && !kernel_mode |=> exc_vector == `VEC_USER_RST;
  endproperty
  a_uvec: assert property (p_uvec) else $error("user miss vector wrong");
  property p_kvec; tlb_lookup && !tlb_hit && xlate_vaddr[31] |=> exc_vector == `VEC_GENERAL_RST; endproperty
  a_kvec: assert property (p_kvec) else $error("kernel miss vector wrong");
  property p_km; exc_take |-> kernel_mode; endproperty
  a_km: assert property (p_km) else $error("entry not in kernel mode");
  property p_cause; exc_take |-> $past(trap_req || (tlb_lookup && !tlb_hit) || irq_in != 0); endproperty
  a_cause: assert property (p_cause) else $error("exception without cause");
  property p_trap; trap_req |=> exc_take && kernel_mode; endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");
  c_umiss: cover property (tlb_lookup && !tlb_hit && !kernel_mode);
  c_nest: cover property (tlb_lookup && !tlb_hit && kernel_mode);
  c_irq: cover property (irq_in != 0 ##1 exc_take);
endmodule
bind translation_miss_exceptions tmx_props #(.IRQ_WIDTH(IRQ_WIDTH)) i_props (
  .sys_clk     (sys_clk),
  .resetn      (resetn),
  .xlate_valid (xlate_valid),
  .xlate_vaddr (xlate_vaddr),
  .tlb_hit     (tlb_hit),
  .tlb_lookup  (tlb_lookup),
  .trap_req    (trap_req),
  .irq_in      (irq_in),
  .exc_take    (exc_take),
  .exc_vector  (exc_vector),
  .kernel_mode (kernel_mode)
);

// File: sim/translation_miss_exceptions_tb.sv
// Testbench for the translation-miss exception unit.
// Assumes the unit's header constants and a 100 MHz clock.
`include "tmx_regs.vh"
module translation_miss_exceptions_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, resetn, xlate_valid, tlb_hit, trap_req, eret, reg_wr, reg_rd;
  logic [31:0] xlate_vaddr, xlate_pc, trap_pc, cur_pc, reg_wdata, q, va, pc;
  logic [5:0]  irq_in, s;
  logic [3:0]  reg_addr;
  wire         tlb_lookup, exc_take, kernel_mode, evt_irq;
  wire  [31:0] exc_vector, reg_rdata;
  int          miscompares, tests_run, tn, i;
  translation_miss_exceptions #(.IRQ_WIDTH(6)) i_dut (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .xlate_valid (xlate_valid),
    .xlate_vaddr (xlate_vaddr),
    .xlate_pc    (xlate_pc),
    .tlb_hit     (tlb_hit),
    .tlb_lookup  (tlb_lookup),
    .trap_req    (trap_req),
    .trap_pc     (trap_pc),
    .eret        (eret),
    .irq_in      (irq_in),
    .cur_pc      (cur_pc),
    .exc_take    (exc_take),
    .exc_vector  (exc_vector),
    .kernel_mode (kernel_mode),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .evt_irq     (evt_irq)
  );
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rd(input [3:0] a, output [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task ev(input v, h, t, r, input [31:0] a);
    @(posedge sys_clk);
    xlate_valid <= v;
    tlb_hit <= h;
    trap_req <= t;
    eret <= r;
    xlate_vaddr <= a;
    xlate_pc <= pc;
    trap_pc <= pc;
    @(posedge sys_clk);
    xlate_valid <= 0;
    trap_req <= 0;
    eret <= 0;
    #1;
  endtask
  function [5:0] psh(input [5:0] x);
    psh = {x[3:0], 2'b01};
  endfunction
  function [5:0] pop(input [5:0] x);
    pop = {x[5:4], x[5:4], x[3:2]};
  endfunction
  task fin;
    $display("test %0d done", tn);
    tn++;
  endtask
  task print_verdict;
    $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #10000;
    miscompares++;
    print_verdict;
  end
  initial begin
    {xlate_valid, tlb_hit, trap_req, eret, reg_wr, reg_rd, resetn} = 0;
    {xlate_vaddr, xlate_pc, trap_pc, reg_wdata, reg_addr, irq_in, pc} = 0;
    void'($urandom(51));
    cur_pc = $urandom;
    repeat (2) @(posedge sys_clk);
    resetn <= 1;
    rd(0, q); chk(q, `ST_RESET);
    rd(8, q); chk(q, `VEC_GENERAL_RST);
    rd(9, q); chk(q, `VEC_USER_RST);
    rd(4'hf, q); chk(q, 0);
    fin;
    for (i = 4; i < 6; i++) begin
      ev(1, 0, 0, 0, {i[2:0], 29'h0} | $urandom & 32'h1fff_ffff);
      chk(exc_take, 0);
    end
    fin;
    s = 6'h02;
    wr(0, s);
    ev(1, 1, 0, 0, 32'h0040_3000);
    chk(exc_take, 0);
    va = $urandom & 32'h7fff_ffff;
    pc = $urandom;
    ev(1, 0, 0, 0, va);
    chk(exc_take, 1);
    chk(exc_vector, `VEC_USER_RST);
    rd(3, q); chk(q & 32'h001f_fffc, {va[30:12], 2'b00});
    rd(2, q); chk(q, pc);
    s = psh(s);
    rd(0, q); chk(q, s);
    fin;
    va = 32'hc000_0000 | $urandom & 32'h3fff_ffff;
    pc = $urandom;
    ev(1, 0, 0, 0, va);
    chk(exc_vector, `VEC_GENERAL_RST);
    rd(2, q); chk(q, pc);
    s = psh(s);
    rd(0, q); chk(q, s);
    rd(4, q); chk(q, va);
    rd(6, q); chk(q, 32'hb);
    repeat (2) begin
      ev(0, 0, 0, 1, 0);
      s = pop(s);
      rd(0, q); chk(q, s);
    end
    chk(kernel_mode, 0);
    fin;
    va = 32'h1 << ($urandom % 6);
    wr(7, 32'h4);
    wr(5, ~va & 32'h3f);
    irq_in <= va[5:0];
    repeat (3) begin
      @(posedge sys_clk);
      #1 chk(exc_take, 0);
    end
    wr(5, va);
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (exc_take === 1) break;
    end
    chk(exc_take, 1);
    chk(evt_irq, 1);
    @(posedge sys_clk);
    irq_in <= 0;
    #1 chk(exc_take, 0);
    rd(1, q); chk(q, `CAUSE_INT);
    wr(6, 32'h4);
    #1 chk(evt_irq, 0);
    fin;
    pc = $urandom;
    ev(0, 0, 1, 0, 0);
    chk(exc_take, 1);
    chk(kernel_mode, 1);
    chk(exc_vector, `VEC_GENERAL_RST);
    rd(1, q); chk(q, `CAUSE_TRAP);
    rd(2, q); chk(q, pc);
    rd(6, q); chk(q, 32'hb);
    s = psh(psh(s));
    rd(0, q); chk(q, s);
    fin;
    print_verdict;
  end
endmodule
